// >>> ctpc_pkg.sv
package ctpc_pkg;
    // 100 MHz logic clock
    localparam int unsigned CLK_PERIOD_NS = 10;
    // internal time base: one second, one minute
    localparam int unsigned SECOND_NS = 1_000_000_000;
    localparam int unsigned SECONDS_PER_MINUTE = 60;
    localparam int unsigned SECOND_CYCLES = SECOND_NS / CLK_PERIOD_NS;
    localparam int unsigned TICK_W = 27;
    localparam int unsigned MINUTE_W = 6;
    localparam int unsigned COUNT_W = 16;
    localparam logic [COUNT_W-1:0] COUNT_RESET = 16'h0000;

    typedef enum logic {
        CTPC_UNIT_SECOND,
        CTPC_UNIT_MINUTE
    } ctpc_unit_t;

    // switches driven by the upstream logic blocks
    typedef struct packed {
        logic run_enable_switch;
        logic hold_or_pulse_switch;
    } ctpc_switch_t;
endpackage

// >>> ctpc_top.sv
// How it works
// - the timer advances on an internal time base while the counter advances only on its pulse input.
// - with its enable switch low the timer holds a zero count and does not count.
// - the timer starts accumulating when its enable switch goes high.
// - a high hold switch pauses the timer, which keeps its count and resumes from it.
// - the timer raises done when its count reaches the preset duration.
// - dropping the timer enable clears both its done status and its count.
// - the counter tallies input pulses and raises done when the tally reaches the preset.
// - dropping the counter run switch clears the tally, stops counting and lowers done.
// - the timer preset is in seconds or minutes, and that unit picks the time base.
// - the finest timer step is one second, counted as SECOND_CYCLES enabled cycles of the 100 MHz clock.
// - inputs are sampled once per cycle and all outputs update together at cycle end.
module ctpc_top
    import ctpc_pkg::*;
(
    // clock, reset, enable
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    // timer side
    input wire ctpc_pkg::ctpc_switch_t i_timer_sw,
    input wire ctpc_pkg::ctpc_unit_t i_timer_unit,
    input wire logic [ctpc_pkg::COUNT_W-1:0] i_timer_preset,
    output logic o_timer_done_status,
    output logic [ctpc_pkg::COUNT_W-1:0] o_timer_count,
    // counter side
    input wire ctpc_pkg::ctpc_switch_t i_counter_sw,
    input wire logic [ctpc_pkg::COUNT_W-1:0] i_counter_preset,
    output logic o_counter_done_status,
    output logic [ctpc_pkg::COUNT_W-1:0] o_counter_count
);
    import ctpc_pkg::*;

    localparam logic [TICK_W-1:0] SEC_LAST = TICK_W'(SECOND_CYCLES - 1);
    localparam logic [MINUTE_W-1:0] MIN_LAST = MINUTE_W'(SECONDS_PER_MINUTE - 1);

    // time base phase
    logic [TICK_W-1:0] tick_q;
    logic [TICK_W-1:0] tick_d;
    logic [MINUTE_W-1:0] sec_q;
    logic [MINUTE_W-1:0] sec_d;

    // timer count and status
    logic [COUNT_W-1:0] tcount_q;
    logic [COUNT_W-1:0] tcount_d;
    logic tdone_q;
    logic tdone_d;

    // counter tally, status and pulse history
    logic [COUNT_W-1:0] ccount_q;
    logic [COUNT_W-1:0] ccount_d;
    logic cdone_q;
    logic cdone_d;
    logic pulse_prev_q;
    logic pulse_prev_d;

    // decoded switches
    logic timer_run;
    logic timer_hold;
    logic per_minute;
    logic counter_run;
    logic pulse_now;
    logic pulse_rise;

    // time base strobes
    logic sec_tick;
    logic unit_tick;

    // preset compare shared by both halves; a preset lowered mid-run ends the run at once, or for a held timer once hold drops
    function automatic logic reached(
        input logic [COUNT_W-1:0] count,
        input logic [COUNT_W-1:0] preset
    );
        reached = (count >= preset);
    endfunction

    always_comb begin
        timer_run = i_timer_sw.run_enable_switch;
        timer_hold = i_timer_sw.hold_or_pulse_switch;
        per_minute = (i_timer_unit == CTPC_UNIT_MINUTE);
        counter_run = i_counter_sw.run_enable_switch;
        pulse_now = i_counter_sw.hold_or_pulse_switch;
        // history is kept while run is low, so a pulse already high at run start is not counted
        pulse_rise = pulse_now && !pulse_prev_q;
    end

    // time base: seconds from the cycle counter, minutes from a second counter
    // limitation: one second is the finest step, so a shorter preset cannot be resolved
    always_comb begin
        tick_d = tick_q;
        sec_d = sec_q;
        sec_tick = 1'b0;
        unit_tick = 1'b0;
        if (!timer_run) begin
            // phase restarts too, so the first unit is a full one
            tick_d = '0;
            sec_d = '0;
        end else if (!tdone_q && !timer_hold) begin
            // sub-second phase is kept across a pause, so paused time is never lost
            sec_tick = (tick_q == SEC_LAST);
            tick_d = sec_tick ? '0 : tick_q + 1'b1;
            if (sec_tick) begin
                if (per_minute) begin
                    unit_tick = (sec_q == MIN_LAST);
                    sec_d = unit_tick ? '0 : sec_q + 1'b1;
                end else begin
                    unit_tick = 1'b1;
                end
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tick_q <= '0;
            sec_q <= '0;
        end else if (i_clk_en) begin
            tick_q <= tick_d;
            sec_q <= sec_d;
        end
    end

    // timer count: one step per time base unit, saturating at the preset
    always_comb begin
        tcount_d = tcount_q;
        tdone_d = tdone_q;
        if (!timer_run) begin
            tcount_d = COUNT_RESET;
            tdone_d = 1'b0;
        end else if (tdone_q) begin
            // saturated: count and done wait for the enable to drop
            tcount_d = tcount_q;
        end else if (!timer_hold) begin
            if (unit_tick) begin
                tcount_d = tcount_q + 1'b1;
            end
            if (reached(tcount_d, i_timer_preset)) begin
                tcount_d = i_timer_preset;
                tdone_d = 1'b1;
            end
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            tcount_q <= COUNT_RESET;
            tdone_q <= 1'b0;
        end else if (i_clk_en) begin
            tcount_q <= tcount_d;
            tdone_q <= tdone_d;
        end
    end

    // counter: one step per rising edge of the pulse input
    always_comb begin
        ccount_d = ccount_q;
        cdone_d = cdone_q;
        pulse_prev_d = pulse_now;
        if (!counter_run) begin
            ccount_d = COUNT_RESET;
            cdone_d = 1'b0;
        end else if (!cdone_q) begin
            // pulses need not outlast one cycle; a one-cycle glitch still counts once
            if (pulse_rise) begin
                ccount_d = ccount_q + 1'b1;
            end
            if (reached(ccount_d, i_counter_preset)) begin
                ccount_d = i_counter_preset;
                cdone_d = 1'b1;
            end
        end
    end

    // a low clock enable freezes the pulse history too, so no edge is made up on wake
    always_ff @(posedge i_clock) begin
        if (i_srst) begin
            ccount_q <= COUNT_RESET;
            cdone_q <= 1'b0;
            pulse_prev_q <= 1'b0;
        end else if (i_clk_en) begin
            ccount_q <= ccount_d;
            cdone_q <= cdone_d;
            pulse_prev_q <= pulse_prev_d;
        end
    end

    // outputs come straight from the state flops, all changing on one edge
    always_comb begin
        o_timer_done_status = tdone_q;
        o_timer_count = tcount_q;
        o_counter_done_status = cdone_q;
        o_counter_count = ccount_q;
    end
endmodule

// >>> ctpc_properties.sv
module ctpc_props (
    input wire logic i_clock,
    input wire logic i_srst,
    input wire logic i_clk_en,
    input wire ctpc_pkg::ctpc_switch_t i_timer_sw,
    input wire logic [ctpc_pkg::COUNT_W-1:0] i_timer_preset,
    input wire logic o_timer_done_status,
    input wire logic [ctpc_pkg::COUNT_W-1:0] o_timer_count,
    input wire ctpc_pkg::ctpc_switch_t i_counter_sw,
    input wire logic [ctpc_pkg::COUNT_W-1:0] i_counter_preset,
    input wire logic o_counter_done_status,
    input wire logic [ctpc_pkg::COUNT_W-1:0] o_counter_count
);
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_srst);
    wire tr = i_timer_sw.run_enable_switch;
    wire th = i_timer_sw.hold_or_pulse_switch;
    wire cr = i_counter_sw.run_enable_switch;
    wire cp = i_counter_sw.hold_or_pulse_switch;
    a_timer_off_clear: assert property (i_clk_en && !tr
        |=> o_timer_count == 16'h0000 && !o_timer_done_status) else $error("timer not clear");
    a_timer_hold_keep: assert property (i_clk_en && tr && th
        |=> $stable(o_timer_count)) else $error("timer moved in hold");
    a_timer_reach_done: assert property (i_clk_en && tr && !th && o_timer_count >= i_timer_preset
        |=> o_timer_done_status) else $error("timer done late");
    a_timer_done_stays: assert property (i_clk_en && tr && o_timer_done_status
        |=> o_timer_done_status) else $error("timer done dropped");
    a_counter_off_clear: assert property (i_clk_en && !cr
        |=> o_counter_count == 16'h0000 && !o_counter_done_status) else $error("counter not clear");
    a_counter_edge_step: assert property (i_clk_en && $past(i_clk_en) && cr && cp && !$past(cp)
        && !o_counter_done_status |=> o_counter_count == $past(o_counter_count) + 16'h0001)
        else $error("counter missed edge");
    a_counter_no_edge: assert property (i_clk_en && $past(i_clk_en) && cr && !(cp && !$past(cp))
        |=> $stable(o_counter_count)) else $error("counter moved");
    a_counter_done_at: assert property ($rose(o_counter_done_status)
        |-> o_counter_count == i_counter_preset) else $error("counter done off preset");
    a_enable_freeze: assert property (!i_clk_en
        |=> $stable(o_counter_count) && $stable(o_timer_count)) else $error("state moved");
    c_timer_done: cover property (o_timer_done_status);
    c_counter_done: cover property (o_counter_done_status);
    c_timer_hold: cover property (tr && th);
endmodule

bind ctpc_top ctpc_props i_props (.i_clock(i_clock), .i_srst(i_srst), .i_clk_en(i_clk_en),
    .i_timer_sw(i_timer_sw), .i_timer_preset(i_timer_preset),
    .o_timer_done_status(o_timer_done_status), .o_timer_count(o_timer_count),
    .i_counter_sw(i_counter_sw), .i_counter_preset(i_counter_preset),
    .o_counter_done_status(o_counter_done_status), .o_counter_count(o_counter_count));

// >>> ctpc_pulse_src.sv
module ctpc_pulse_src (
    input wire logic i_clock,
    input wire logic i_gate,
    output logic o_pulse
);
    timeunit 1ns;
    timeprecision 1ns;
    logic raw = 1'h0;
    // blocking at the source or a low clock enable are the only ways to pause the counter
    assign o_pulse = raw & i_gate;
    task automatic send(input int n);
        repeat (n) begin
            @(negedge i_clock) raw = 1'h1;
            repeat (2) @(negedge i_clock);
            raw = 1'h0;
            repeat (2) @(negedge i_clock);
        end
    endtask
endmodule

// >>> cycle_timer_and_pulse_counter_tb.sv
`define CHK(a, e) num_checks++; if ((a) !== (e)) begin n_fail++; $display("Error %0t bad value", $time); end
module cycle_timer_and_pulse_counter_tb;
    timeunit 1ns;
    timeprecision 1ns;
    import ctpc_pkg::*;
    logic clk = 1'h0, srst = 1'h1, en = 1'h1, run = 1'h0, gate = 1'h1, pulse, tdone, cdone;
    ctpc_switch_t tsw = '0, csw;
    ctpc_unit_t unit = CTPC_UNIT_SECOND;
    logic [COUNT_W-1:0] tcnt, ccnt, tpre = 16'h0001, cpre = 16'h0003;
    int n_fail = 0, num_checks = 0, cycles = 0;
    assign csw = {run, pulse};
    ctpc_top i_dut (.i_clock(clk), .i_srst(srst), .i_clk_en(en), .i_timer_sw(tsw),
        .i_timer_unit(unit), .i_timer_preset(tpre), .o_timer_done_status(tdone),
        .o_timer_count(tcnt), .i_counter_sw(csw), .i_counter_preset(cpre),
        .o_counter_done_status(cdone), .o_counter_count(ccnt));
    ctpc_pulse_src i_src (.i_clock(clk), .i_gate(gate), .o_pulse(pulse));
    initial forever #5 clk = ~clk;
    task print_verdict;
        if (n_fail == 0 && num_checks > 0) $display("[ PASS ]");
        else $display("[ FAIL ]");
        $finish;
    endtask
    always @(posedge clk) if (++cycles > 500) begin
        n_fail++;
        print_verdict();
    end
    initial begin
        repeat (3) @(negedge clk);
        srst = 1'h0;
        for (int u = 0; u < 2; u++) begin
            unit = ctpc_unit_t'(u);
            tpre = 16'h0001;
            tsw = 2'h2;
            repeat (2) @(negedge clk);
            `CHK({tdone, tcnt}, 17'h00000)
            tsw = 2'h3;
            tpre = 16'h0000;
            repeat (2) @(negedge clk);
            `CHK({tdone, tcnt}, 17'h00000)
            tsw = 2'h2;
            repeat (2) @(negedge clk);
            `CHK(tdone, 1'h1)
            tsw = 2'h0;
            @(negedge clk);
            `CHK({tdone, tcnt}, 17'h00000)
        end
        run = 1'h1;
        i_src.send(2);
        `CHK(ccnt, 16'h0002)
        gate = 1'h0;
        i_src.send(1);
        `CHK(ccnt, 16'h0002)
        gate = 1'h1;
        en = 1'h0;
        i_src.send(1);
        `CHK(ccnt, 16'h0002)
        en = 1'h1;
        i_src.send(3);
        `CHK({cdone, ccnt}, 17'h10003)
        run = 1'h0;
        @(negedge clk);
        `CHK({cdone, ccnt}, 17'h00000)
        print_verdict();
    end
endmodule
